//--- pxr_pkg.sv
package pxr_pkg;
	localparam int ONCHIP_XDATA_RAM_BYTES = 1024;
	localparam int ONCHIP_XDATA_RAM_AW = 10;
	localparam int XDATA_AW = 16;
	localparam int DATA_W = 8;
	localparam int SHORT_AW = 8;
	localparam int PAGE_W = 2;
	localparam int SFR_AW = 8;
	localparam logic [SFR_AW-1:0] PAGE_SEL_ADDR = 8'haf;
	localparam logic [PAGE_W-1:0] PAGE_SEL_RESET = 2'h0;
	localparam logic [DATA_W-PAGE_W-1:0] PAGE_SEL_PAD = 6'h00;
	localparam logic [DATA_W-1:0] SFR_IDLE_DATA = 8'h00;
	typedef logic [ONCHIP_XDATA_RAM_AW-1:0] pxr_addr_t;
	typedef logic [DATA_W-1:0] pxr_byte_t;
endpackage

//--- pxr_port_if.sv
`timescale 1ns/1ns
interface pxr_port_if;
	import pxr_pkg::*;
	logic      en;
	logic      we;
	pxr_addr_t addr;
	pxr_byte_t wdata;
	pxr_byte_t rdata;
	modport ctrl (output en, output we, output addr, output wdata,
		input rdata);
	modport mem (input en, input we, input addr, input wdata,
		output rdata);
endinterface

//--- pxr_ram.sv
`timescale 1ns/1ns
module pxr_ram
	import pxr_pkg::*;
#(
	parameter int DEPTH = ONCHIP_XDATA_RAM_BYTES
)
(
	input  wire logic core_clk_i,
	pxr_port_if.mem   port
);
	import pxr_pkg::*;

	pxr_byte_t mem_q [DEPTH];
	pxr_byte_t rdata_q;

	// The array has no reset, so contents are undefined until written.
	always_ff @(posedge core_clk_i)
	begin
		if (port.en && port.we)
			mem_q[port.addr] <= port.wdata;
		if (port.en)
			rdata_q <= mem_q[port.addr];
	end

	assign port.rdata = rdata_q;
endmodule

//--- pxr_top.sv
`timescale 1ns/1ns
// Overview of operation
// - Holds 1024 bytes of read/write RAM in external data space.
// - Every byte is readable and writable by both pointer and indirect forms.
// - Short 8-bit transfers take RAM address bits 9:8 from page select.
// - Short transfers reach one of four 256-byte pages by page bits 1:0.
// - Transfers hit this RAM unless a write is steered to flash.
// - The top six bits of the 16-bit address are ignored.
// - RAM repeats every 1024 bytes across the full 64K space.
module pxr_top
	import pxr_pkg::*;
(
	input  wire logic                        core_clk_i,
	input  wire logic                        rst_n_i,
	input  wire logic                        xm_req_i,
	input  wire logic                        xm_we_i,
	input  wire logic                        xm_short_i,
	input  wire logic                        xm_flash_redirect_i,
	input  wire logic [pxr_pkg::XDATA_AW-1:0] xm_addr_i,
	input  wire logic [pxr_pkg::DATA_W-1:0]  xm_wdata_i,
	output logic      [pxr_pkg::DATA_W-1:0]  xm_rdata_o,
	output logic                             xm_ack_o,
	input  wire logic [pxr_pkg::SFR_AW-1:0]  sfr_addr_i,
	input  wire logic                        sfr_wr_i,
	input  wire logic                        sfr_rd_i,
	input  wire logic [pxr_pkg::DATA_W-1:0]  sfr_wdata_i,
	output logic      [pxr_pkg::DATA_W-1:0]  sfr_rdata_o,
	output logic                             sfr_hit_o,
	output logic      [pxr_pkg::PAGE_W-1:0]  page_o
);
	import pxr_pkg::*;

	pxr_port_if port ();

	// Registered state and its next values.
	logic [PAGE_W-1:0] page;
	logic [PAGE_W-1:0] next_page;
	pxr_byte_t         sfr_rdata;
	pxr_byte_t         next_sfr_rdata;
	logic              sfr_hit;
	logic              next_sfr_hit;
	logic              ack;
	logic              next_ack;

	// Decoded strobes and the RAM address.
	logic              sel_page;
	logic              page_write;
	logic              page_read;
	logic              take;
	logic              ram_write;
	pxr_addr_t         short_addr;
	pxr_addr_t         full_addr;
	pxr_addr_t         ram_addr;

	// The core drives every request on this clock, so no input here is
	// synchronised; a request from another domain would need that first.
	always_comb
	begin
		sel_page = (sfr_addr_i == PAGE_SEL_ADDR);
	end

	always_comb
	begin
		page_write = sel_page && sfr_wr_i;
	end

	always_comb
	begin
		page_read = sel_page && sfr_rd_i;
	end

	// Only the low field has storage, so bits 7:2 of a write are lost.
	always_comb
	begin
		next_page = page;
		if (page_write)
		begin
			next_page = sfr_wdata_i[PAGE_W-1:0];
		end
	end

	// Reset clears the field; the pad bits are never stored at all.
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			page <= PAGE_SEL_RESET;
		end
		else
		begin
			page <= next_page;
		end
	end

	// The hit flag lasts one cycle for each read strobe.
	always_comb
	begin
		next_sfr_hit = 1'b0;
		if (page_read)
		begin
			next_sfr_hit = 1'b1;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sfr_hit <= 1'b0;
		end
		else
		begin
			sfr_hit <= next_sfr_hit;
		end
	end

	// Read-back returns to zero when idle, so that several registers can
	// share one return bus through a plain OR.
	always_comb
	begin
		next_sfr_rdata = SFR_IDLE_DATA;
		if (page_read)
		begin
			next_sfr_rdata = {PAGE_SEL_PAD, page};
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sfr_rdata <= SFR_IDLE_DATA;
		end
		else
		begin
			sfr_rdata <= next_sfr_rdata;
		end
	end

	// A write steered to flash is answered by the flash path, not here;
	// reads are never steered and always come from this RAM.
	always_comb
	begin
		ram_write = xm_we_i && !xm_flash_redirect_i;
	end

	always_comb
	begin
		take = xm_req_i && (!xm_we_i || ram_write);
	end

	// Dropping the top six address bits is what makes the RAM repeat
	// every 1024 bytes. A short transfer in the same cycle as a page
	// write still uses the old page.
	always_comb
	begin
		short_addr = {page, xm_addr_i[SHORT_AW-1:0]};
		full_addr = xm_addr_i[ONCHIP_XDATA_RAM_AW-1:0];
		if (xm_short_i)
		begin
			ram_addr = short_addr;
		end
		else
		begin
			ram_addr = full_addr;
		end
	end

	// Write data stays at zero except on a write, which keeps the write
	// bus of the array from toggling on every read.
	always_comb
	begin
		port.en = take;
		port.we = take && ram_write;
		port.addr = ram_addr;
		if (take && ram_write)
		begin
			port.wdata = xm_wdata_i;
		end
		else
		begin
			port.wdata = '0;
		end
	end

	// A refused write gets no answer at all, so the core must not wait
	// for one after steering a write to flash.
	always_comb
	begin
		next_ack = take;
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ack <= 1'b0;
		end
		else
		begin
			ack <= next_ack;
		end
	end

	// Depth follows the package so that address width and array agree.
	pxr_ram #(
		.DEPTH (ONCHIP_XDATA_RAM_BYTES)
	) u_ram (
		.core_clk_i (core_clk_i),
		.port       (port.mem)
	);

	// Read data comes straight from the output register of the array and
	// holds until the next accepted transfer.
	assign xm_rdata_o = port.rdata;
	assign xm_ack_o = ack;
	assign sfr_rdata_o = sfr_rdata;
	assign sfr_hit_o = sfr_hit;
	assign page_o = page;
endmodule

//--- pxr_chk_sva.sv
`timescale 1ns/1ns
module pxr_chk
(
	input  wire logic       core_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       xm_req_i,
	input  wire logic       xm_we_i,
	input  wire logic       xm_flash_redirect_i,
	input  wire logic       xm_ack_o,
	input  wire logic [7:0] sfr_addr_i,
	input  wire logic       sfr_wr_i,
	input  wire logic       sfr_rd_i,
	input  wire logic [7:0] sfr_wdata_i,
	input  wire logic       sfr_hit_o,
	input  wire logic [7:0] sfr_rdata_o,
	input  wire logic [1:0] page_o
);
	default clocking cb_core @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	a_ack_taken: assert property ($past(xm_req_i) &&
		!($past(xm_we_i) && $past(xm_flash_redirect_i)) |-> xm_ack_o)
		else $error("taken transfer not acknowledged");
	a_redir_quiet: assert property ($past(xm_req_i) &&
		$past(xm_we_i) && $past(xm_flash_redirect_i) |-> !xm_ack_o)
		else $error("redirected write acknowledged");
	a_page_write: assert property ($past(sfr_wr_i) &&
		$past(sfr_addr_i) == pxr_pkg::PAGE_SEL_ADDR |->
		{6'h0, page_o} == ($past(sfr_wdata_i) & 8'h03))
		else $error("page write not stored");
	a_page_hold: assert property (!($past(sfr_wr_i) &&
		$past(sfr_addr_i) == pxr_pkg::PAGE_SEL_ADDR) |->
		page_o == $past(page_o))
		else $error("page changed without write");
	a_read_hit: assert property ($past(sfr_rd_i) &&
		$past(sfr_addr_i) == pxr_pkg::PAGE_SEL_ADDR |-> sfr_hit_o)
		else $error("page read not answered");
	a_idle_zero: assert property (!sfr_hit_o |->
		sfr_rdata_o == 8'h00) else $error("read bus not idle");
	a_ack_req: assert property (xm_ack_o |-> $past(xm_req_i))
		else $error("ack without request");
	a_hit_page: assert property (sfr_hit_o |->
		sfr_rdata_o == {6'h0, $past(page_o)}) else $error("bad page read");
	cover property (xm_ack_o);
	cover property (sfr_hit_o);
	cover property (page_o == 2'h3);
endmodule

//--- pxr_core.sv
`timescale 1ns/1ns
module pxr_core (input wire logic core_clk_i,
	output logic [27:0] cmd_o = 28'h0);
	task automatic xfer(input logic [27:0] c);
		@(negedge core_clk_i) cmd_o = c;
		@(negedge core_clk_i) cmd_o[27] = 1'h0;
	endtask
endmodule

//--- paged_xdata_ram_test.sv
`timescale 1ns/1ns
module paged_xdata_ram_test;
	logic core_clk_i = 1'h0, rst_n_i = 1'h0, sfr_wr_i = 1'h0, sfr_rd_i = 1'h0;
	logic xm_req_i, xm_we_i, xm_short_i, xm_flash_redirect_i, xm_ack_o;
	logic [15:0] xm_addr_i;
	logic [7:0] xm_wdata_i, xm_rdata_o, sfr_rdata_o, sfr_wdata_i = 8'h0;
	logic [7:0] sfr_addr_i = pxr_pkg::PAGE_SEL_ADDR;
	logic [1:0] page_o;
	logic sfr_hit_o;
	int err_total = 0, comparisons = 0;
	always #5 core_clk_i = ~core_clk_i;
	pxr_top i_dut (.*);
	pxr_core i_core (.core_clk_i, .cmd_o({xm_req_i, xm_we_i, xm_short_i,
		xm_flash_redirect_i, xm_addr_i, xm_wdata_i}));
	task chk(input logic [15:0] s, e);
		comparisons++;
		err_total += (s !== e);
		if (s !== e)
			$display("ERROR %0t %h %h", $time, s, e);
	endtask
	task sfr(input logic w, input logic [7:0] d);
		@(negedge core_clk_i) {sfr_wr_i, sfr_rd_i, sfr_wdata_i} = {w, !w, d};
		@(negedge core_clk_i) {sfr_wr_i, sfr_rd_i} = 2'h0;
	endtask
	task t_alias;
		i_core.xfer({4'hc, 16'h0005, 8'h5a});
		i_core.xfer({4'hd, 16'h0005, 8'hee});
		chk(xm_ack_o, 1'h0);
		i_core.xfer({4'h9, 16'hfc05, 8'h00});
		chk({xm_ack_o, xm_rdata_o}, 9'h15a);
	endtask
	task t_pages;
		for (int p = 0; p < 4; p++)
		begin
			sfr(1'h1, 8'hfc | 8'(p));
			i_core.xfer({4'he, 16'hff33, 8'(p)});
			sfr(1'h0, 8'h00);
			chk({sfr_hit_o, sfr_rdata_o}, {1'h1, 8'(p)});
			i_core.xfer({4'h8, 6'h2a, 2'(p), 8'h33, 8'h00});
			chk(xm_rdata_o, 8'(p));
			i_core.xfer({4'ha, 16'h0033, 8'h00});
			chk(xm_rdata_o, 8'(p));
		end
	endtask
	task t_refuse;
		sfr_addr_i = 8'hb0;
		sfr(1'h1, 8'h01);
		sfr(1'h0, 8'h00);
		chk({sfr_hit_o, sfr_rdata_o}, 9'h000);
		chk(page_o, 2'h3);
		sfr_addr_i = pxr_pkg::PAGE_SEL_ADDR;
	endtask
	task test_done;
		$display("mismatches %0d checks %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (16) @(negedge core_clk_i);
		rst_n_i = 1'h1;
		chk(page_o, 2'h0);
		t_alias;
		t_pages;
		t_refuse;
		test_done;
	end
endmodule
bind pxr_top pxr_chk u_chk (
	.core_clk_i          (core_clk_i),
	.rst_n_i             (rst_n_i),
	.xm_req_i            (xm_req_i),
	.xm_we_i             (xm_we_i),
	.xm_flash_redirect_i (xm_flash_redirect_i),
	.xm_ack_o            (xm_ack_o),
	.sfr_addr_i          (sfr_addr_i),
	.sfr_wr_i            (sfr_wr_i),
	.sfr_rd_i            (sfr_rd_i),
	.sfr_wdata_i         (sfr_wdata_i),
	.sfr_hit_o           (sfr_hit_o),
	.sfr_rdata_o         (sfr_rdata_o),
	.page_o              (page_o)
);
